// >>> core/acr_pkg.sv
// Package: offsets, field positions and carrier types of the capability bank
package acr_pkg;

  // Register byte offsets in the device memory region
  localparam logic [11:0] OFS_QUEUE_CAP = 12'h020;
  localparam logic [11:0] OFS_GROUP_CAP = 12'h030;
  localparam logic [11:0] OFS_ENGINE_CAP = 12'h038;
  localparam logic [11:0] OFS_OP_MASK = 12'h040;
  localparam int OP_MASK_WORDS = 4;
  localparam int WORD_BYTES = 8;
  localparam int CAP_WORDS = 7;

  // work_queue_capabilities fields
  localparam int QCAP_OCC_INT_BIT = 53;
  localparam int QCAP_OCC_RPT_BIT = 52;
  localparam int QCAP_PRIO_BIT = 51;
  localparam int QCAP_DEDICATED_BIT = 49;
  localparam int QCAP_SHARED_BIT = 48;
  localparam int QCAP_COUNT_LSB = 16;
  localparam int QCAP_SIZE_LSB = 0;

  // group_capabilities fields
  localparam int GCAP_GLOBAL_LIMIT_BIT = 17;
  localparam int GCAP_TOKENS_BIT = 16;
  localparam int GCAP_TOKENS_LSB = 8;
  localparam int GCAP_COUNT_LSB = 0;

  // engine_capabilities field
  localparam int ECAP_COUNT_LSB = 0;

  // Reset values
  localparam logic [63:0] RDATA_RESET = 64'h0;
  localparam logic [15:0] OCC_RESET = 16'h0;

  // Register access request from the memory-mapped fabric
  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [63:0] wdata;
  } acr_req_t;

  // Per-queue configuration fields whose meaning depends on capabilities
  typedef struct packed {
    logic enable;
    logic dedicated;
    logic [3:0] priority_lvl;
    logic [15:0] occ_limit;
    logic occ_int_en;
  } acr_queue_cfg_t;

  // Per-group token fields
  typedef struct packed {
    logic [7:0] tokens_allowed;
    logic [7:0] tokens_reserved;
    logic use_global_limit;
  } acr_group_cfg_t;

endpackage

// >>> core/acr_cap_word.sv
// One read-only 64-bit capability word with its own address decode
`timescale 1ns/1ps
module acr_cap_word #(
  parameter logic [11:0] OFFSET = 12'h000,
  parameter logic [63:0] VALUE = 64'h0
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Decode
  input wire logic [11:0] addr_in,
  output logic hit_out,
  output logic [63:0] data_out
);

  logic [63:0] value_r;

  // Constant held in flops so the value is fixed from reset onward
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      value_r <= VALUE;
    end else begin
      value_r <= VALUE;
    end
  end

  assign hit_out = (addr_in == OFFSET);
  assign data_out = hit_out ? value_r : 64'h0;

endmodule

// >>> core/acr_capability_regs.sv
// Capability register bank of the data-movement accelerator
`timescale 1ns/1ps
module acr_capability_regs #(
  parameter logic OCC_INT_SUPPORTED = 1'b1,
  parameter logic OCC_RPT_SUPPORTED = 1'b1,
  parameter logic PRIO_SUPPORTED = 1'b1,
  parameter logic DEDICATED_SUPPORTED = 1'b1,
  parameter logic SHARED_SUPPORTED = 1'b1,
  parameter logic [15:0] TOTAL_QUEUE_SIZE = 16'h0080,
  parameter logic [7:0] NUM_QUEUES = 8'h08,
  parameter logic GLOBAL_LIMIT_SUPPORTED = 1'b1,
  parameter logic TOKENS_SUPPORTED = 1'b1,
  parameter logic [7:0] TOTAL_TOKENS = 8'h10,
  parameter logic [7:0] NUM_GROUPS = 8'h04,
  parameter logic [7:0] NUM_ENGINES = 8'h04,
  parameter logic [255:0] OP_DEFINED = 256'hffff,
  parameter logic [255:0] OP_SUPPORTED = 256'hffff
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Register access
  input wire acr_pkg::acr_req_t req_in,
  output logic [63:0] rdata_out,
  output logic ack_out,
  // Queue configuration qualification
  input wire acr_pkg::acr_queue_cfg_t queue_cfg_in,
  input wire logic [15:0] queue_fill_in,
  output acr_pkg::acr_queue_cfg_t queue_cfg_eff_out,
  output logic [15:0] queue_occupancy_out,
  output logic queue_mode_err_out,
  // Group configuration qualification
  input wire acr_pkg::acr_group_cfg_t group_cfg_in,
  input wire logic [7:0] global_limit_in,
  output acr_pkg::acr_group_cfg_t group_cfg_eff_out,
  output logic [7:0] global_limit_eff_out
);

  // Undefined opcodes are forced clear whatever the build asks for
  localparam logic [255:0] OP_MASK = OP_SUPPORTED & OP_DEFINED;

  // Unused ranges stay zero because only named fields are ORed in
  localparam logic [63:0] QUEUE_CAP_VAL =
    (64'(OCC_INT_SUPPORTED) << acr_pkg::QCAP_OCC_INT_BIT) |
    (64'(OCC_RPT_SUPPORTED) << acr_pkg::QCAP_OCC_RPT_BIT) |
    (64'(PRIO_SUPPORTED) << acr_pkg::QCAP_PRIO_BIT) |
    (64'(DEDICATED_SUPPORTED) << acr_pkg::QCAP_DEDICATED_BIT) |
    (64'(SHARED_SUPPORTED) << acr_pkg::QCAP_SHARED_BIT) |
    (64'(NUM_QUEUES) << acr_pkg::QCAP_COUNT_LSB) |
    (64'(TOTAL_QUEUE_SIZE) << acr_pkg::QCAP_SIZE_LSB);

  localparam logic [63:0] GROUP_CAP_VAL =
    (64'(GLOBAL_LIMIT_SUPPORTED) << acr_pkg::GCAP_GLOBAL_LIMIT_BIT) |
    (64'(TOKENS_SUPPORTED) << acr_pkg::GCAP_TOKENS_BIT) |
    (64'(TOTAL_TOKENS) << acr_pkg::GCAP_TOKENS_LSB) |
    (64'(NUM_GROUPS) << acr_pkg::GCAP_COUNT_LSB);

  localparam logic [63:0] ENGINE_CAP_VAL = 64'(NUM_ENGINES) << acr_pkg::ECAP_COUNT_LSB;

  localparam logic [63:0] WORD_VAL [acr_pkg::CAP_WORDS] = '{
    QUEUE_CAP_VAL, GROUP_CAP_VAL, ENGINE_CAP_VAL,
    OP_MASK[63:0], OP_MASK[127:64], OP_MASK[191:128], OP_MASK[255:192]};

  localparam logic [11:0] WORD_OFS [acr_pkg::CAP_WORDS] = '{
    acr_pkg::OFS_QUEUE_CAP, acr_pkg::OFS_GROUP_CAP, acr_pkg::OFS_ENGINE_CAP,
    acr_pkg::OFS_OP_MASK, acr_pkg::OFS_OP_MASK + 12'h008,
    acr_pkg::OFS_OP_MASK + 12'h010, acr_pkg::OFS_OP_MASK + 12'h018};

  logic [63:0] word_data [acr_pkg::CAP_WORDS];
  logic [acr_pkg::CAP_WORDS-1:0] word_hit;
  logic [63:0] rd_mux;
  logic [63:0] rdata_nxt;
  logic ack_nxt;

  genvar gi;
  generate
    for (gi = 0; gi < acr_pkg::CAP_WORDS; gi++) begin : g_word
      acr_cap_word #(
        .OFFSET(WORD_OFS[gi]),
        .VALUE(WORD_VAL[gi])
      ) u_word (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .addr_in(req_in.addr),
        .hit_out(word_hit[gi]),
        .data_out(word_data[gi])
      );
    end
  endgenerate

  // At most one word hits, so an OR tree is the read mux
  always_comb begin
    rd_mux = 64'h0;
    for (int i = 0; i < acr_pkg::CAP_WORDS; i++) begin
      rd_mux = rd_mux | word_data[i];
    end
  end

  // Writes are acknowledged but change nothing; unmapped reads give zero
  assign rdata_nxt = req_in.rd ? rd_mux : acr_pkg::RDATA_RESET;
  assign ack_nxt = req_in.rd | req_in.wr;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_out <= acr_pkg::RDATA_RESET;
      ack_out <= 1'b0;
    end else begin
      rdata_out <= rdata_nxt;
      ack_out <= ack_nxt;
    end
  end

  // Queue configuration seen by the rest of the device
  acr_pkg::acr_queue_cfg_t queue_cfg_nxt;
  logic [15:0] queue_occ_nxt;
  logic queue_mode_err_nxt;

  always_comb begin
    queue_cfg_nxt = queue_cfg_in;
    if (!OCC_INT_SUPPORTED) begin
      queue_cfg_nxt.occ_limit = 16'h0;
      queue_cfg_nxt.occ_int_en = 1'b0;
    end
    if (!PRIO_SUPPORTED) begin
      queue_cfg_nxt.priority_lvl = 4'h0;
    end
  end

  // Unsupported reporting reads as zero rather than stale data
  assign queue_occ_nxt = OCC_RPT_SUPPORTED ? queue_fill_in : acr_pkg::OCC_RESET;

  // Flags a queue enabled in a mode the build lacks
  assign queue_mode_err_nxt = queue_cfg_in.enable &
    ((queue_cfg_in.dedicated & !DEDICATED_SUPPORTED) |
     (!queue_cfg_in.dedicated & !SHARED_SUPPORTED));

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      queue_cfg_eff_out <= '0;
      queue_occupancy_out <= acr_pkg::OCC_RESET;
      queue_mode_err_out <= 1'b0;
    end else begin
      queue_cfg_eff_out <= queue_cfg_nxt;
      queue_occupancy_out <= queue_occ_nxt;
      queue_mode_err_out <= queue_mode_err_nxt;
    end
  end

  // Group token fields seen by the rest of the device
  acr_pkg::acr_group_cfg_t group_cfg_nxt;
  logic [7:0] global_limit_nxt;

  always_comb begin
    group_cfg_nxt = group_cfg_in;
    if (!TOKENS_SUPPORTED) begin
      group_cfg_nxt.tokens_allowed = 8'h00;
      group_cfg_nxt.tokens_reserved = 8'h00;
    end
    if (!GLOBAL_LIMIT_SUPPORTED) begin
      group_cfg_nxt.use_global_limit = 1'b0;
    end
  end

  assign global_limit_nxt = GLOBAL_LIMIT_SUPPORTED ? global_limit_in : 8'h00;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      group_cfg_eff_out <= '0;
      global_limit_eff_out <= 8'h00;
    end else begin
      group_cfg_eff_out <= group_cfg_nxt;
      global_limit_eff_out <= global_limit_nxt;
    end
  end

endmodule

// >>> dv/acr_capability_checker.sv
// Port assertions for the capability bank
`timescale 1ns/1ps
module acr_capability_checker #(
  parameter logic OCC_INT_SUPPORTED = 1'b1,
  parameter logic OCC_RPT_SUPPORTED = 1'b1,
  parameter logic PRIO_SUPPORTED = 1'b1,
  parameter logic TOKENS_SUPPORTED = 1'b1
) (
  // Clock, reset, register port
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire acr_pkg::acr_req_t req_in,
  input wire logic [63:0] rdata_out,
  input wire logic ack_out,
  // Qualification paths
  input wire acr_pkg::acr_queue_cfg_t queue_cfg_in,
  input wire logic [15:0] queue_fill_in,
  input wire acr_pkg::acr_queue_cfg_t queue_cfg_eff_out,
  input wire logic [15:0] queue_occupancy_out,
  input wire acr_pkg::acr_group_cfg_t group_cfg_in,
  input wire acr_pkg::acr_group_cfg_t group_cfg_eff_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  wire logic req_w = req_in.rd | req_in.wr;
  wire logic [11:0] a_w = req_in.addr;
  a_ack_after_req: assert property (req_w |=> ack_out) else $error("ack missing");
  a_ack_no_req: assert property (!req_w |=> !ack_out) else $error("ack without request");
  a_rdata_idle: assert property (!req_in.rd |=> rdata_out == 64'h0) else $error("rdata not zero");
  a_queue_word_bits: assert property (req_in.rd && a_w == acr_pkg::OFS_QUEUE_CAP |=> rdata_out[63:54] == 10'h0
    && rdata_out[50] == 1'b0 && rdata_out[47:24] == 24'h0 && rdata_out[53] == OCC_INT_SUPPORTED
    && rdata_out[52] == OCC_RPT_SUPPORTED && rdata_out[51] == PRIO_SUPPORTED) else $error("queue word");
  a_group_word_bits: assert property (req_in.rd && a_w == acr_pkg::OFS_GROUP_CAP |=> rdata_out[63:18] == 46'h0
    && rdata_out[16] == TOKENS_SUPPORTED) else $error("group word");
  a_engine_upper_zero: assert property (req_in.rd && a_w == acr_pkg::OFS_ENGINE_CAP |=> rdata_out[63:8] == 56'h0)
    else $error("engine upper bits");
  a_occ_limit_resv: assert property (1'b1 |=> queue_cfg_eff_out.occ_limit == (OCC_INT_SUPPORTED ?
    $past(queue_cfg_in.occ_limit) : 16'h0)) else $error("occupancy limit");
  a_occ_report: assert property (1'b1 |=> queue_occupancy_out == (OCC_RPT_SUPPORTED ? $past(queue_fill_in) : 16'h0))
    else $error("occupancy");
  a_prio_ignored: assert property (1'b1 |=> queue_cfg_eff_out.priority_lvl == (PRIO_SUPPORTED ?
    $past(queue_cfg_in.priority_lvl) : 4'h0)) else $error("priority");
  a_tokens_inert: assert property (1'b1 |=> group_cfg_eff_out.tokens_allowed == (TOKENS_SUPPORTED ?
    $past(group_cfg_in.tokens_allowed) : 8'h0)) else $error("tokens");
  c_mask_read: cover property (req_in.rd && a_w == acr_pkg::OFS_OP_MASK);
  c_write: cover property (req_in.wr && !req_in.rd);
  c_fill_change: cover property (queue_fill_in != $past(queue_fill_in));
endmodule
bind acr_capability_regs acr_capability_checker #(.OCC_INT_SUPPORTED(OCC_INT_SUPPORTED),
  .OCC_RPT_SUPPORTED(OCC_RPT_SUPPORTED), .PRIO_SUPPORTED(PRIO_SUPPORTED), .TOKENS_SUPPORTED(TOKENS_SUPPORTED))
  u_checker (.clk_in(clk_in), .reset_n_in(reset_n_in), .req_in(req_in), .rdata_out(rdata_out), .ack_out(ack_out),
  .queue_cfg_in(queue_cfg_in), .queue_fill_in(queue_fill_in), .queue_cfg_eff_out(queue_cfg_eff_out),
  .queue_occupancy_out(queue_occupancy_out), .group_cfg_in(group_cfg_in), .group_cfg_eff_out(group_cfg_eff_out));

// >>> dv/acr_capability_regs_tb.sv
// Self-checking bench for the capability bank
`timescale 1ns/1ps
module acr_capability_regs_tb;
  // Mixed feature set so reserved-field handling is exercised
  localparam logic OI = 1'b0, ORP = 1'b1, PR = 1'b0, DED = 1'b0, SH = 1'b1, GL = 1'b0, TK = 1'b1;
  localparam logic [255:0] OPD = {4{64'h00ff}}, OPS = {4{64'h0f0f}};
  logic clk = 1'b0, reset_n = 1'b0, ack, merr;
  acr_pkg::acr_req_t req = '0;
  acr_pkg::acr_queue_cfg_t qcfg = '0, qeff, eq;
  acr_pkg::acr_group_cfg_t gcfg = '0, geff, eg;
  logic [15:0] fill = 16'h0, occ;
  logic [7:0] glim = 8'h0, gleff;
  logic [63:0] rdata;
  logic [31:0] rnd = 32'd86;
  int fail_count = 0, total_checks = 0;
  logic [11:0] addrs [10] = '{12'h020, 12'h030, 12'h038, 12'h040, 12'h048, 12'h050, 12'h058, 12'h028, 12'h021, 12'h060};
  acr_capability_regs #(.OCC_INT_SUPPORTED(OI), .OCC_RPT_SUPPORTED(ORP), .PRIO_SUPPORTED(PR),
    .DEDICATED_SUPPORTED(DED), .SHARED_SUPPORTED(SH), .TOTAL_QUEUE_SIZE(16'h0123), .NUM_QUEUES(8'h05),
    .GLOBAL_LIMIT_SUPPORTED(GL), .TOKENS_SUPPORTED(TK), .TOTAL_TOKENS(8'h20), .NUM_GROUPS(8'h03),
    .NUM_ENGINES(8'h06), .OP_DEFINED(OPD), .OP_SUPPORTED(OPS)) u_acr_capability_regs (.clk_in(clk),
    .reset_n_in(reset_n), .req_in(req), .rdata_out(rdata), .ack_out(ack), .queue_cfg_in(qcfg), .queue_fill_in(fill),
    .queue_cfg_eff_out(qeff), .queue_occupancy_out(occ), .queue_mode_err_out(merr), .group_cfg_in(gcfg),
    .global_limit_in(glim), .group_cfg_eff_out(geff), .global_limit_eff_out(gleff));
  initial begin
    forever #2 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [63:0] exp_word(input logic [11:0] a);
    logic [255:0] m;
    m = OPS & OPD;
    case (a)
      12'h020: exp_word = {10'h0, OI, ORP, PR, 1'b0, DED, SH, 24'h0, 8'h05, 16'h0123};
      12'h030: exp_word = {46'h0, GL, TK, 8'h20, 8'h03};
      12'h038: exp_word = {56'h0, 8'h06};
      12'h040: exp_word = m[63:0];
      12'h048: exp_word = m[127:64];
      12'h050: exp_word = m[191:128];
      12'h058: exp_word = m[255:192];
      default: exp_word = 64'h0;
    endcase
  endfunction
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // Request held one cycle; the next call issues back to back
  task automatic access(input logic rd, input logic wr, input logic [11:0] a);
    rnd = lfsr(rnd);
    req = '{rd: rd, wr: wr, addr: a, wdata: {rnd, ~rnd}};
    @(negedge clk);
    chk("ack", 64'h1, {63'h0, ack});
    chk("rdata", rd ? exp_word(a) : 64'h0, rdata);
  endtask
  task automatic idle();
    req = '0;
    @(negedge clk);
    chk("ack_idle", 64'h0, {63'h0, ack});
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    for (int i = 0; i < 10; i++) access(1'b1, 1'b0, addrs[i]);
    idle();
    for (int i = 0; i < 10; i++) access(i[0], 1'b1, addrs[i]);
    for (int i = 0; i < 10; i++) access(1'b1, 1'b0, addrs[i]);
    idle();
    for (int i = 0; i < 40; i++) begin
      rnd = lfsr(rnd);
      qcfg = acr_pkg::acr_queue_cfg_t'(rnd[22:0]);
      fill = (i == 3) ? 16'hffff : rnd[31:16];
      gcfg = acr_pkg::acr_group_cfg_t'(rnd[31:15]);
      glim = rnd[7:0] ^ rnd[15:8];
      eq = qcfg;
      eg = gcfg;
      if (!OI) begin
        eq.occ_limit = '0;
        eq.occ_int_en = 1'b0;
      end
      if (!PR) eq.priority_lvl = '0;
      if (!TK) eg.tokens_allowed = '0;
      if (!TK) eg.tokens_reserved = '0;
      if (!GL) eg.use_global_limit = 1'b0;
      @(negedge clk);
      chk("queue_cfg", 64'(eq), 64'(qeff));
      chk("occupancy", ORP ? 64'(fill) : 64'h0, 64'(occ));
      chk("mode_err", 64'(qcfg.enable & (qcfg.dedicated & !DED | !qcfg.dedicated & !SH)), 64'(merr));
      chk("group_cfg", 64'(eg), 64'(geff));
      chk("global_limit", GL ? 64'(glim) : 64'h0, 64'(gleff));
    end
    wrap_up();
  end
endmodule
